// ### inc/crs_map.svh
// Timing counts and widths for the card reset sequencer
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// Counter width, wide enough for the longest count in card clock cycles
`define CRS_CNT_W        16

// All counts are in card clock cycles
`define CRS_RX_HIGH_CYC  16'h00C8
`define CRS_RST_LOW_CYC  16'h9C40
`define CRS_RST_HIGH_CYC 16'h9C40
`define CRS_ANS_MIN_CYC  16'h0190
`define CRS_ANS_MAX_CYC  16'h9C40

`endif

// ### inc/crs_pkg.sv
// Types for the card reset sequencer
package crs_pkg;

   typedef enum logic [2:0] {
      CRS_ST_IDLE,
      CRS_ST_LOW,
      CRS_ST_HIGH,
      CRS_ST_DONE
   } crs_state_t;

endpackage

// ### verilog/crs_sync.sv
// Two-stage synchroniser for levels entering the clk domain
`timescale 1ns/1ps
`default_nettype none

module crs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ### verilog/crs_seq.sv
// Start-up reset sequencer for an active-low-reset smart card
//
// Notes on behaviour
// - Card clock starts after power-up; T0.
// - Reset held low 40000 cycles from T0.
// - Reset driven high after low phase; T1.
// - Reset held high 40000 cycles after T1.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"

module crs_seq #(
   parameter logic [`CRS_CNT_W-1:0] RST_LOW_CYC  = `CRS_RST_LOW_CYC,
   parameter logic [`CRS_CNT_W-1:0] RST_HIGH_CYC = `CRS_RST_HIGH_CYC,
   parameter logic [`CRS_CNT_W-1:0] ANS_MAX_CYC  = `CRS_ANS_MAX_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic card_clk_src,
   input  wire logic card_rx,
   output var  logic card_clk,
   output var  logic card_rst_n,
   output var  logic seq_busy,
   output var  logic answer_seen,
   output var  logic err_rx_idle,
   output var  logic err_answer_early,
   output var  logic err_answer_late
);

   import crs_pkg::*;

   function automatic logic rose(input logic cur, input logic prev);
      rose = cur & ~prev;
   endfunction

   logic [1:0]            sync_q;
   logic                  src_s;
   logic                  rx_s;
   logic                  src_prev_reg;
   logic                  rx_prev_reg;
   logic                  card_edge;
   logic                  rx_fall;
   crs_state_t            state_reg;
   crs_state_t            state_next;
   logic [`CRS_CNT_W-1:0] cnt_reg;
   logic                  clk_en_reg;
   logic                  answered_reg;

   // Both the card clock source and the receive line are asynchronous pins
   crs_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({card_rx, card_clk_src}),
      .q     (sync_q)
   );

   assign src_s = sync_q[0];
   assign rx_s  = sync_q[1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_reg <= 1'b0;
         rx_prev_reg  <= 1'b0;
      end else begin
         src_prev_reg <= src_s;
         rx_prev_reg  <= rx_s;
      end
   end

   // One card clock cycle is counted per rising edge of the gated source
   assign card_edge = clk_en_reg & rose(src_s, src_prev_reg);
   // Start bit of the answer; rx_prev resets low so no false edge at start
   assign rx_fall   = rose(rx_prev_reg, rx_s);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CRS_ST_IDLE: begin
            state_next = CRS_ST_LOW;
         end
         CRS_ST_LOW: begin
            // First counted edge may trail T0; one more edge keeps a full low time
            if (card_edge && cnt_reg == RST_LOW_CYC) begin
               state_next = CRS_ST_HIGH;
            end
         end
         CRS_ST_HIGH: begin
            // Leave on the RST_HIGH_CYC-th counted edge; ANS_MAX_CYC plays no part in the exit
            if (card_edge && cnt_reg == RST_HIGH_CYC - 16'h0001) begin
               state_next = CRS_ST_DONE;
            end
         end
         CRS_ST_DONE: begin
            state_next = CRS_ST_DONE;
         end
         default: begin
            state_next = CRS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= CRS_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Counter restarts at T0 and again at T1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (state_reg != state_next) begin
         cnt_reg <= '0;
      end else if (card_edge && state_reg != CRS_ST_DONE) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // Clock enabled once after reset and left running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_en_reg <= 1'b0;
         card_clk   <= 1'b0;
      end else begin
         if (state_reg == CRS_ST_IDLE) begin
            clk_en_reg <= 1'b1;
         end
         card_clk <= clk_en_reg & src_s;
      end
   end

   // Reset stays high for good after T1, which covers the minimum hold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         card_rst_n <= 1'b0;
      end else begin
         card_rst_n <= (state_next == CRS_ST_HIGH) || (state_next == CRS_ST_DONE);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_busy <= 1'b1;
      end else begin
         seq_busy <= state_next != CRS_ST_DONE;
      end
   end

   // The card's own idle level is checked once, at the 200th cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_rx_idle <= 1'b0;
      end else if (state_reg == CRS_ST_LOW && card_edge &&
                   cnt_reg == `CRS_RX_HIGH_CYC - 16'h0001 && !rx_s) begin
         err_rx_idle <= 1'b1;
      end
   end

   // Only the first start bit after T1 counts as the answer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         answered_reg <= 1'b0;
         answer_seen  <= 1'b0;
      end else if (state_reg == CRS_ST_HIGH && rx_fall && !answered_reg) begin
         answered_reg <= 1'b1;
         answer_seen  <= cnt_reg >= `CRS_ANS_MIN_CYC && cnt_reg < ANS_MAX_CYC;
      end
   end

   // An answer during the low phase is as wrong as one before 400 cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_answer_early <= 1'b0;
      end else if (rx_fall && (state_reg == CRS_ST_LOW ||
                   (state_reg == CRS_ST_HIGH && !answered_reg &&
                    cnt_reg < `CRS_ANS_MIN_CYC))) begin
         err_answer_early <= 1'b1;
      end
   end

   // No start bit by the window end; a later one cannot clear this
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_answer_late <= 1'b0;
      end else if (state_reg == CRS_ST_HIGH && !answered_reg && !rx_fall &&
                   card_edge && cnt_reg >= ANS_MAX_CYC - 16'h0001) begin
         // Judged on the closing edge itself, since HIGH may end on that same edge
         err_answer_late <= 1'b1;
      end else if (state_reg == CRS_ST_HIGH && !answered_reg && rx_fall &&
                   cnt_reg >= ANS_MAX_CYC) begin
         err_answer_late <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// ### dv/crs_seq_properties.sv
// Timing checker for the card reset sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_seq_properties #(
   parameter int RST_LOW_CYC  = 500,
   parameter int RST_HIGH_CYC = 500,
   parameter int ANS_MAX_CYC  = 500
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic card_clk,
   input wire logic card_rst_n,
   input wire logic seq_busy,
   input wire logic answer_seen,
   input wire logic err_answer_early,
   input wire logic err_answer_late
);
   logic ck_q;
   logic rs_q;
   int   n;
   // Card clock rises since the reset line last moved; one edge of slack covers a partial first pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_q <= 1'h0;
         rs_q <= 1'h0;
         n    <= 0;
      end else begin
         ck_q <= card_clk;
         rs_q <= card_rst_n;
         n    <= (rs_q != card_rst_n) ? 0 : n + int'(card_clk && !ck_q);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_clk_running: assert property (seq_busy |-> ##[1:24] $changed(card_clk))
      else $error("card clock stalled");
   a_low_phase: assert property ($rose(card_rst_n) |-> n >= RST_LOW_CYC && n <= RST_LOW_CYC + 1)
      else $error("reset low phase length wrong");
   a_high_stays: assert property (card_rst_n |=> card_rst_n)
      else $error("card reset dropped after release");
   a_hold_done: assert property ($fell(seq_busy) |-> card_rst_n && n >= RST_HIGH_CYC - 1)
      else $error("busy ended before high hold");
   a_late_flag: assert property ($rose(err_answer_late) |-> n >= ANS_MAX_CYC - 1)
      else $error("late flag raised too soon");
   cover property ($rose(answer_seen));
   cover property ($rose(err_answer_early));
   cover property ($rose(err_answer_late));
endmodule
bind crs_seq crs_seq_properties #(.RST_LOW_CYC(RST_LOW_CYC), .RST_HIGH_CYC(RST_HIGH_CYC),
   .ANS_MAX_CYC(ANS_MAX_CYC)) u_props (.*);
`default_nettype wire

// ### dv/crs_card.sv
// Behavioural card with an active-low reset input
`timescale 1ns/1ps
`default_nettype none
module crs_card (
   input  wire logic        card_clk,
   input  wire logic        card_rst_n,
   input  wire logic        rx_ok,
   input  wire logic [16:0] ans_at,
   output var  logic        card_rx
);
   int n;
   always @(posedge card_clk or negedge card_rst_n) begin
      if (!card_rst_n) n <= 0;
      else n <= n + 1;
   end
   // Drives rx_ok in reset; the start bit is a ten-cycle low pulse at the commanded count
   assign card_rx = card_rst_n ? !(n >= ans_at && n < ans_at + 10) : rx_ok;
endmodule
`default_nettype wire

// ### dv/card_active_low_reset_seq_test.sv
// Self-checking bench for the card reset sequencer
`timescale 1ns/1ps
`default_nettype none
module card_active_low_reset_seq_test;
   logic        clk = 1'h0, rst_n = 1'h0, src = 1'h0, rx_ok = 1'h1;
   logic        rx, cclk, crst_n, busy, seen, idl, erl, lat;
   logic [16:0] ans_at = 17'h0;
   logic [4:0]  exp_q[$];
   int          error_cnt = 0, n_checks = 0;
   // Card clock rises seen while the reset line is still low
   int          ck_n = 0;
   int          ck_exp[$];
   logic        cclk_q = 1'h0;
   localparam int LOW_CYC = 500;
   always #5 clk = ~clk;
   // Free-running card clock source, 160 ns period
   always begin
      repeat (8) @(posedge clk);
      src <= ~src;
   end
   crs_seq #(.RST_LOW_CYC(16'h01F4), .RST_HIGH_CYC(16'h01F4), .ANS_MAX_CYC(16'h01F4)) uut (
      .clk(clk), .rst_n(rst_n), .card_clk_src(src), .card_rx(rx), .card_clk(cclk),
      .card_rst_n(crst_n), .seq_busy(busy), .answer_seen(seen), .err_rx_idle(idl),
      .err_answer_early(erl), .err_answer_late(lat));
   crs_card card (.card_clk(cclk), .card_rst_n(crst_n), .rx_ok(rx_ok), .ans_at(ans_at),
      .card_rx(rx));
   task automatic check(input logic [4:0] ex, input logic [4:0] got);
      n_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("MISMATCH status exp %h got %h", ex, got);
      end
   endtask
   // An uncounted partial first pulse may add one rise
   task automatic check_cnt(input int lo, input int got);
      n_checks++;
      if (got < lo || got > lo + 1) begin
         error_cnt++;
         $display("MISMATCH low_phase_clocks exp %0d got %0d", lo, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cclk_q <= cclk;
      if (!rst_n) ck_n <= 0;
      else if (cclk && !cclk_q && !crst_n) ck_n <= ck_n + 1;
   end
   always @(posedge crst_n) begin
      #1;
      check_cnt(ck_exp.pop_front(), ck_n);
   end
   always @(negedge busy) begin
      #1;
      check(exp_q.pop_front(), {crst_n, idl, erl, lat, seen});
   end
   initial begin
      #800_000;
      error_cnt++;
      tally_and_finish;
   end
   // Runs: answer in window, early answer, no answer, receive line low at edge 200
   initial begin
      void'($urandom(32'h3997));
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rst_n <= 1'h0;
         rx_ok <= (i != 3);
         ans_at <= (i == 1) ? 50 + $urandom % 300 : (i == 2) ? 99999 : 410 + $urandom % 80;
         exp_q.push_back(i == 1 ? 5'h14 : i == 2 ? 5'h12 : i == 3 ? 5'h19 : 5'h11);
         ck_exp.push_back(LOW_CYC);
         repeat (10) @(posedge clk);
         rst_n <= 1'h1;
         repeat (20000) begin
            @(posedge clk);
            if (!busy) break;
         end
         if (busy) begin
            error_cnt++;
            $display("MISMATCH seq_busy exp 0 got 1");
         end
      end
      repeat (5) @(posedge clk);
      tally_and_finish;
   end
endmodule
`default_nettype wire
